// file: eep_map.vh
`ifndef EEP_MAP_VH
`define EEP_MAP_VH
`define EEP_CTRL_CODE 4'ha
`define EEP_CLK_PERIOD_NS 10
`define EEP_WC_TIME_MS 5
`define EEP_WC_CYCLES (`EEP_WC_TIME_MS * 1000000 / `EEP_CLK_PERIOD_NS)
`define EEP_WC_CNT_W 19
`define EEP_ADDR_W 15
`define EEP_PAGE_W 6
`define EEP_BASE_W 9
`define EEP_LAST_IDX 6'h3f
`define EEP_ACK_BIT 4'h8
`define EEP_MEM_WORDS 32768
`define EEP_PAGE_WORDS 64
`define EEP_FIFO_DEPTH 2
`define EEP_FIFO_AW 1
`define EEP_FIFO_W 14
`endif

// file: eep_client.v
`include "eep_map.vh"
`default_nettype none
// two-entry skid buffer between byte receiver and page buffer
module eep_fifo #(
  parameter WIDTH = `EEP_FIFO_W,
  parameter DEPTH = `EEP_FIFO_DEPTH,
  parameter AW = `EEP_FIFO_AW
) (
  input wire clk_sys,
  input wire srst,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] slot [0:DEPTH-1];
  reg [AW:0] wr_ptr_reg;
  reg [AW:0] rd_ptr_reg;
  wire empty = (wr_ptr_reg == rd_ptr_reg);
  wire full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
    (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = slot[rd_ptr_reg[AW-1:0]];
  always @(posedge clk_sys) begin
    if (srst) begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full) begin
        slot[wr_ptr_reg[AW-1:0]] <= in_data;
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule

// Function
// [RQ1] host owns clock, arbitration, Start and Stop; memory is only client
// [RQ2] host starts a transfer only while both lines idle high
// [RQ3] SDA falling with SCL high is Start, detected anywhere
// [RQ4] SDA rising with SCL high is Stop, always detected
// [RQ5] SDA changes only while SCL low; one bit per clock
// [RQ6] receiver pulls SDA low through the ninth clock after each byte
// [RQ7] host nacks last read byte; device releases SDA for Stop
// [RQ8] control byte acked only for code 1010 and matching chip selects
// [RQ9] control byte bit zero: one reads, zero writes
// [RQ10] two address bytes follow a write, high first, fifteen bits used
// [RQ11] byte write acks four bytes; Stop starts the write cycle
// [RQ12] no byte acknowledged while a write cycle runs
// [RQ13] after a byte write the pointer sits one past it
// [RQ14] protected write still acked, nothing stored, ready at once
// [RQ15] write protect sampled at Stop; later changes ignored
// [RQ16] up to 63 more bytes buffered, committed only after Stop
// [RQ17] only six low pointer bits advance; last 64 bytes kept
// [RQ18] page writes wrap inside the same aligned page
// [RQ19] short page write leaves unwritten bytes with old contents
// [RQ20] hosts without chip-select pins send zeros in those bits
// [RQ21] sequential read never continues into another device
// [RQ22] write control byte nacked until cycle ends, then acked
// [RQ23] read pointer advances per byte, wraps 7fff to 0000
// [RQ24] write cycle length is a parameterised timer on clk_sys
// [RQ25] SDA driven only low as open drain, released otherwise
module eep_client #(
  parameter WC_CYCLES = `EEP_WC_CYCLES
) (
  input wire clk_sys,
  input wire srst,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output reg sda_oe,
  input wire wp_in,
  input wire chip_select_pin_zero,
  input wire chip_select_pin_one,
  input wire chip_select_pin_two,
  output wire wr_busy
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_CTRL = 3'h1;
  localparam [2:0] ST_ADDRH = 3'h2;
  localparam [2:0] ST_ADDRL = 3'h3;
  localparam [2:0] ST_WDATA = 3'h4;
  localparam [2:0] ST_RDATA = 3'h5;
  localparam [1:0] CP_IDLE = 2'h0;
  localparam [1:0] CP_DRAIN = 2'h1;
  localparam [1:0] CP_WRITE = 2'h2;
  localparam [1:0] CP_TIMER = 2'h3;
  localparam [`EEP_WC_CNT_W-1:0] WC_LAST =
    WC_CYCLES[`EEP_WC_CNT_W-1:0] - 1'b1;
  reg [7:0] mem [0:`EEP_MEM_WORDS-1];
  reg [7:0] pbuf [0:`EEP_PAGE_WORDS-1];
  reg scl_m_reg, scl_s_reg, scl_d_reg;
  reg sda_m_reg, sda_s_reg, sda_d_reg;
  reg [3:0] pin_m_reg, pin_s_reg;
  reg [2:0] state_reg;
  reg [2:0] nxt_reg;
  reg [3:0] bit_cnt_reg;
  reg in_ack_reg;
  reg ack_drv_reg;
  reg tx_en_reg;
  reg host_ack_reg;
  reg [7:0] rx_sh_reg;
  reg [7:0] tx_sh_reg;
  reg [`EEP_ADDR_W-1:0] ptr_reg;
  reg [`EEP_BASE_W-1:0] page_reg;
  reg wr_pend_reg;
  reg commit_req_reg;
  reg clr_req_reg;
  reg push_reg;
  reg [`EEP_FIFO_W-1:0] push_data_reg;
  reg [1:0] cphase_reg;
  reg [`EEP_PAGE_W-1:0] cidx_reg;
  reg [`EEP_BASE_W-1:0] base_reg;
  reg [`EEP_PAGE_WORDS-1:0] mask_reg;
  reg [`EEP_WC_CNT_W-1:0] wc_cnt_reg;
  wire scl_rise, scl_fall, start_det, stop_det;
  wire wp_s;
  wire [2:0] cs_s;
  wire busy;
  wire cs_match;
  wire f_in_ready, f_out_valid, f_out_ready;
  wire [`EEP_FIFO_W-1:0] f_out_data;
  wire sda_oe_next;
  assign wp_s = pin_s_reg[3];
  assign cs_s = pin_s_reg[2:0];
  assign scl_rise = scl_s_reg & ~scl_d_reg;
  assign scl_fall = ~scl_s_reg & scl_d_reg;
  assign start_det = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg; // [RQ3]
  assign stop_det = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg; // [RQ4]
  assign busy = (cphase_reg != CP_IDLE);
  assign wr_busy = busy;
  assign cs_match = (rx_sh_reg[7:4] == `EEP_CTRL_CODE) &&
    (rx_sh_reg[3:1] == cs_s); // [RQ8]
  // line is only ever pulled low
  assign sda_out = 1'b0; // [RQ25]
  assign sda_oe_next = ack_drv_reg | (tx_en_reg & ~tx_sh_reg[7]); // [RQ25]
  assign f_out_ready = (cphase_reg != CP_WRITE);
  always @(posedge clk_sys) begin
    if (srst) begin
      scl_m_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      pin_m_reg <= 4'h0;
      pin_s_reg <= 4'h0;
      sda_oe <= 1'b0;
    end else begin
      scl_m_reg <= scl_in;
      scl_s_reg <= scl_m_reg;
      scl_d_reg <= scl_s_reg;
      sda_m_reg <= sda_in;
      sda_s_reg <= sda_m_reg;
      sda_d_reg <= sda_s_reg;
      pin_m_reg <= {wp_in, chip_select_pin_two, chip_select_pin_one,
        chip_select_pin_zero};
      pin_s_reg <= pin_m_reg;
      sda_oe <= sda_oe_next;
    end
  end
  eep_fifo u_fifo (
    .clk_sys(clk_sys),
    .srst(srst),
    .in_data(push_data_reg),
    .in_valid(push_reg),
    .in_ready(f_in_ready),
    .out_data(f_out_data),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready)
  );
  // byte engine, stepped by sampled SCL edges
  always @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      nxt_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      in_ack_reg <= 1'b0;
      ack_drv_reg <= 1'b0;
      tx_en_reg <= 1'b0;
      host_ack_reg <= 1'b0;
      rx_sh_reg <= 8'h00;
      tx_sh_reg <= 8'hff;
      ptr_reg <= {`EEP_ADDR_W{1'b0}};
      page_reg <= {`EEP_BASE_W{1'b0}};
      wr_pend_reg <= 1'b0;
      commit_req_reg <= 1'b0;
      clr_req_reg <= 1'b0;
      push_reg <= 1'b0;
      push_data_reg <= {`EEP_FIFO_W{1'b0}};
    end else begin
      commit_req_reg <= 1'b0;
      clr_req_reg <= 1'b0;
      push_reg <= 1'b0;
      if (start_det || stop_det) begin
        state_reg <= start_det ? ST_CTRL : ST_IDLE; // [RQ3] [RQ4]
        bit_cnt_reg <= 4'h0;
        in_ack_reg <= 1'b0;
        ack_drv_reg <= 1'b0;
        tx_en_reg <= 1'b0;
        wr_pend_reg <= 1'b0;
        commit_req_reg <= stop_det & wr_pend_reg & ~wp_s; // [RQ11] [RQ15]
        clr_req_reg <= start_det | (wr_pend_reg & wp_s); // [RQ14]
      end else if (state_reg != ST_IDLE) begin
        if (scl_rise) begin
          if (!in_ack_reg) begin
            rx_sh_reg <= {rx_sh_reg[6:0], sda_s_reg}; // [RQ5]
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
          end else if (state_reg == ST_RDATA) begin
            host_ack_reg <= ~sda_s_reg;
            ptr_reg <= ptr_reg + 1'b1; // [RQ23] [RQ21]
          end
        end else if (scl_fall) begin
          if (in_ack_reg) begin
            in_ack_reg <= 1'b0;
            ack_drv_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            if (state_reg == ST_RDATA) begin
              if (host_ack_reg) begin
                tx_sh_reg <= mem[ptr_reg];
                tx_en_reg <= 1'b1;
              end else begin
                state_reg <= ST_IDLE; // [RQ7]
              end
            end else begin
              state_reg <= nxt_reg;
              if (nxt_reg == ST_RDATA) begin
                tx_sh_reg <= mem[ptr_reg];
                tx_en_reg <= 1'b1;
              end
            end
          end else if (bit_cnt_reg == `EEP_ACK_BIT) begin
            in_ack_reg <= 1'b1;
            tx_en_reg <= 1'b0; // [RQ25]
            case (state_reg)
              ST_CTRL: begin
                if (cs_match && !busy) begin
                  ack_drv_reg <= 1'b1; // [RQ6] [RQ22]
                  nxt_reg <= rx_sh_reg[0] ? ST_RDATA : ST_ADDRH; // [RQ9]
                end else begin
                  state_reg <= ST_IDLE; // [RQ12] [RQ22]
                end
              end
              ST_ADDRH: begin
                ptr_reg[14:8] <= rx_sh_reg[6:0]; // [RQ10]
                ack_drv_reg <= 1'b1;
                nxt_reg <= ST_ADDRL;
              end
              ST_ADDRL: begin
                ptr_reg[7:0] <= rx_sh_reg; // [RQ10]
                ack_drv_reg <= 1'b1;
                nxt_reg <= ST_WDATA;
              end
              ST_WDATA: begin
                if (f_in_ready) begin
                  push_reg <= 1'b1; // [RQ16]
                  push_data_reg <= {ptr_reg[5:0], rx_sh_reg};
                  page_reg <= ptr_reg[14:6]; // [RQ18]
                  ptr_reg[5:0] <= ptr_reg[5:0] + 1'b1; // [RQ13] [RQ17]
                  wr_pend_reg <= 1'b1;
                  ack_drv_reg <= 1'b1; // [RQ11] [RQ14]
                  nxt_reg <= ST_WDATA;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end
              ST_RDATA: begin
                ack_drv_reg <= 1'b0; // [RQ7] [RQ25]
              end
              default: begin
                state_reg <= ST_IDLE;
              end
            endcase
          end else if (state_reg == ST_RDATA) begin
            tx_sh_reg <= {tx_sh_reg[6:0], 1'b1}; // [RQ5]
          end
        end
      end
    end
  end
  // page buffer, commit into array, write-cycle timer
  always @(posedge clk_sys) begin
    if (srst) begin
      cphase_reg <= CP_IDLE;
      cidx_reg <= {`EEP_PAGE_W{1'b0}};
      base_reg <= {`EEP_BASE_W{1'b0}};
      mask_reg <= {`EEP_PAGE_WORDS{1'b0}};
      wc_cnt_reg <= {`EEP_WC_CNT_W{1'b0}};
    end else begin
      case (cphase_reg)
        CP_IDLE: begin
          if (commit_req_reg) begin
            cphase_reg <= CP_DRAIN;
            base_reg <= page_reg;
          end else if (clr_req_reg) begin
            mask_reg <= {`EEP_PAGE_WORDS{1'b0}}; // [RQ14]
          end
        end
        CP_DRAIN: begin
          if (!f_out_valid) begin
            cphase_reg <= CP_WRITE;
            cidx_reg <= {`EEP_PAGE_W{1'b0}};
          end
        end
        CP_WRITE: begin
          if (mask_reg[cidx_reg]) begin
            mem[{base_reg, cidx_reg}] <= pbuf[cidx_reg]; // [RQ18] [RQ19]
          end
          cidx_reg <= cidx_reg + 1'b1;
          if (cidx_reg == `EEP_LAST_IDX) begin
            cphase_reg <= CP_TIMER;
            mask_reg <= {`EEP_PAGE_WORDS{1'b0}};
            wc_cnt_reg <= {`EEP_WC_CNT_W{1'b0}};
          end
        end
        CP_TIMER: begin
          wc_cnt_reg <= wc_cnt_reg + 1'b1; // [RQ24]
          if (wc_cnt_reg == WC_LAST) begin
            cphase_reg <= CP_IDLE; // [RQ22]
          end
        end
        default: begin
          cphase_reg <= CP_IDLE;
        end
      endcase
      if (f_out_valid && f_out_ready) begin
        pbuf[f_out_data[13:8]] <= f_out_data[7:0]; // [RQ17]
        mask_reg[f_out_data[13:8]] <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: eep_client_chk.sv
`default_nettype none
module eep_client_chk #(
  parameter WC_CYCLES = 200
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic wp_in,
  input wire logic wr_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  int bcnt_reg;
  int bcnt_next;
  // busy cycles since the write cycle began
  always @* bcnt_next = wr_busy ? bcnt_reg + 1 : 0;
  always @(posedge clk_sys) bcnt_reg <= srst ? 0 : bcnt_next;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_pull_low_only: assert property (sda_oe |-> !sda_out && !sda_in)
    else $error("sda line not low while device drives it");
  a_idle_after_reset: assert property ($fell(srst) |->
    !sda_oe && !wr_busy) else $error("outputs active after reset");
  a_oe_scl_low: assert property (!$past(srst) && $changed(sda_oe) |->
    !scl_in && !$past(scl_in, 2)) else $error("sda_oe moved near scl high");
  a_no_ack_busy: assert property ($rose(sda_oe) |-> !wr_busy)
    else $error("ack given during write cycle");
  a_busy_length: assert property ($fell(wr_busy) |->
    bcnt_reg >= WC_CYCLES + 64 && bcnt_reg <= WC_CYCLES + 90)
    else $error("write cycle length off");
  a_busy_at_stop: assert property ($rose(wr_busy) |->
    scl_in && sda_in && !$past(sda_in, 6))
    else $error("write cycle began without stop");
  a_wp_no_cycle: assert property (!wr_busy && wp_in && scl_in &&
    $rose(sda_in) |=> !wr_busy [*8]) else $error("protected write ran");
  a_start_release: assert property (scl_in && $fell(sda_in) |=>
    !sda_oe [*8]) else $error("sda held after start");
endmodule
bind eep_client eep_client_chk #(.WC_CYCLES(WC_CYCLES)) u_chk (
  .clk_sys(clk_sys), .srst(srst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .wp_in(wp_in), .wr_busy(wr_busy));
`default_nettype wire

// file: eep_host_bfm.sv
`default_nettype none
module eep_host_bfm (
  input wire logic clk_sys,
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic hc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // one 160 ns bit, data moved only while scl low
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    hc(4);
    scl = 1'b1;
    hc(4);
    r = sda_line;
    hc(4);
    scl = 1'b0;
    hc(4);
  endtask
  task automatic start;
    sda_drv = 1'b1;
    hc(4);
    scl = 1'b1;
    hc(8);
    sda_drv = 1'b0;
    hc(8);
    scl = 1'b0;
    hc(4);
  endtask
  task automatic stop;
    sda_drv = 1'b0;
    hc(4);
    scl = 1'b1;
    hc(8);
    sda_drv = 1'b1;
    hc(8);
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule
`default_nettype wire

// file: testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic wp_in = 1'b0;
  logic [2:0] cs = 3'b101;
  logic scl;
  logic hsda;
  logic [7:0] d;
  wire sda_out;
  wire sda_oe;
  wire wr_busy;
  // pull-up wired with host and device pull-downs
  wire sda_line = hsda & ~sda_oe;
  int fail_count = 0;
  int checked = 0;
  always #5 clk_sys = ~clk_sys;
  eep_host_bfm host (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl),
    .sda_drv(hsda));
  eep_client #(.WC_CYCLES(200)) dut (.clk_sys(clk_sys), .srst(srst),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .wp_in(wp_in), .chip_select_pin_zero(cs[0]),
    .chip_select_pin_one(cs[1]), .chip_select_pin_two(cs[2]),
    .wr_busy(wr_busy));
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  function automatic logic [7:0] ctl(input logic rw);
    return {4'ha, cs, rw};
  endfunction
  task automatic wb(input string nm, input logic [7:0] v, input logic e);
    logic a;
    host.send(v, a);
    chk(nm, {7'h0, a}, {7'h0, e});
  endtask
  task automatic addr(input logic [14:0] a);
    host.start();
    wb("ctl_w", ctl(1'b0), 1'b1);
    wb("adr_hi", {1'b0, a[14:8]}, 1'b1);
    wb("adr_lo", a[7:0], 1'b1);
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] v[$]);
    addr(a);
    foreach (v[i]) wb("wr_data", v[i], 1'b1);
    host.stop();
  endtask
  task automatic rd(input logic [14:0] a, input logic [7:0] e[$]);
    addr(a);
    host.start();
    wb("ctl_r", ctl(1'b1), 1'b1);
    foreach (e[i]) begin
      host.recv(i == e.size() - 1, d);
      chk("rd_data", d, e[i]);
    end
    host.stop();
  endtask
  task automatic idle_wait;
    int n;
    n = 0;
    while (wr_busy === 1'b1 && n < 5000) begin
      @(negedge clk_sys);
      n++;
    end
    chk("busy_end", {7'h0, wr_busy}, 8'h0);
  endtask
  initial begin
    #(900_000);
    fail_count++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(negedge clk_sys);
    srst = 1'b0;
    host.hc(4);
    wr(15'h01fe, {8'h11, 8'h22, 8'h33, 8'h44});
    host.hc(10);
    chk("busy_on", {7'h0, wr_busy}, 8'h1);
    host.start();
    wb("poll_busy", ctl(1'b0), 1'b0);
    host.stop();
    idle_wait();
    host.start();
    wb("poll_idle", ctl(1'b0), 1'b1);
    host.stop();
    rd(15'h01c0, {8'h33, 8'h44});
    rd(15'h01fe, {8'h11, 8'h22});
    $display("test page_wrap done");
    wr(15'h01fd, {8'h5a});
    wp_in = 1'b1;
    idle_wait();
    host.start();
    wb("ctl_cur", ctl(1'b1), 1'b1);
    host.recv(1'b1, d);
    chk("cur_rd", d, 8'h11);
    host.stop();
    rd(15'h01fd, {8'h5a});
    wr(15'h01fd, {8'hee});
    host.hc(4);
    chk("wp_busy", {7'h0, wr_busy}, 8'h0);
    rd(15'h01fd, {8'h5a});
    wp_in = 1'b0;
    $display("test protect done");
    for (int k = 1; k < 8; k++) begin
      host.start();
      wb("ctl_bad", ctl(1'b0) ^ (8'h01 << k), 1'b0);
      host.stop();
    end
    cs = 3'b010;
    host.hc(8);
    wr(15'h7fff, {8'h3c});
    idle_wait();
    wr(15'h0000, {8'hc3});
    idle_wait();
    rd(15'h7fff, {8'h3c, 8'hc3});
    $display("test select_wrap done");
    cs = 3'b000;
    host.hc(8);
    addr(15'h0400);
    for (int i = 0; i < 66; i++) wb("pg_data", 8'h10 + i[7:0], 1'b1);
    host.stop();
    idle_wait();
    wr(15'h0402, {8'h99});
    idle_wait();
    rd(15'h0400, {8'h50, 8'h51, 8'h99, 8'h13});
    $display("test page_overrun done");
    report_and_stop();
  end
endmodule
`default_nettype wire
